// File: src/char_fifo.sv
// Small shift-down character buffer with registered head
`default_nettype none
module char_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 2
) (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset
  input wire logic push_i, // Store data_i
  input wire logic [WIDTH-1:0] data_i, // Character in
  input wire logic pop_i, // Drop head
  output logic [WIDTH-1:0] head_o, // Oldest character
  output logic empty_o, // No character held
  output logic full_o // No room left
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
  logic [WIDTH-1:0] slot [DEPTH];
  logic [CW-1:0] count;
  logic do_pop;
  logic do_push;
  logic [CW-1:0] wr_idx;

  assign do_pop = pop_i && (count != '0);
  assign do_push = push_i && ((count != DEPTH_C) || do_pop);
  assign wr_idx = do_pop ? count - CW'(1) : count;
  assign head_o = slot[0];
  assign empty_o = (count == '0);
  assign full_o = (count == DEPTH_C);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count <= '0;
    end else if (do_push && !do_pop) begin
      count <= count + CW'(1);
    end else if (do_pop && !do_push) begin
      count <= count - CW'(1);
    end
  end

  for (genvar i = 0; i < DEPTH; i++) begin : g_slot
    localparam logic [CW-1:0] IDX = CW'(i);
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        slot[i] <= '0;
      end else if (do_push && wr_idx == IDX) begin
        slot[i] <= data_i;
      end else if (do_pop) begin
        slot[i] <= (i < DEPTH - 1) ? slot[(i + 1) % DEPTH] : slot[i];
      end
    end
  end
endmodule
`default_nettype wire

// File: src/sync_slave_serial_port.sv
// Synchronous slave serial port with Wishbone register access
//
// Local design decisions: the Wishbone slave port and the address map.
`include "sync_slave_serial_port_consts.svh"
`default_nettype none
module sync_slave_serial_port (
  input wire logic clk_i, // System clock, 40 MHz
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write
  input wire logic [7:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte lanes
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Wishbone acknowledge
  input wire logic link_clock_pin_i, // Clock pin level
  output logic link_clock_pin_o, // Clock pin drive value
  output logic link_clock_pin_oe_o, // Clock pin drive enable
  input wire logic link_data_pin_i, // Data pin level
  output logic link_data_pin_o, // Data pin drive value
  output logic link_data_pin_oe_o, // Data pin drive enable
  input wire logic sleep_i, // Core is sleeping
  output logic wake_o, // Wake the core
  output logic interrupt_o // Vector to service routine
);
  logic [7:0] core_interrupt_control;
  logic [7:0] peripheral_interrupt_enables;
  logic [7:0] port_c_direction;
  logic [7:3] rx_ctrl;
  logic [7:0] tx_ctrl;
  logic [2:0] clk_sync;
  logic [1:0] dat_sync;
  logic lead_edge;
  logic trail_edge;
  logic slave_mode;
  logic tx_mode;
  logic rx_mode;
  logic wb_req;
  logic wb_wr;
  logic [31:0] next_rd_data;
  sync_slave_serial_port_pkg::tx_state_t tx_state;
  sync_slave_serial_port_pkg::rx_state_t rx_state;
  logic [8:0] transmit_data_buffer;
  logic txbuf_full;
  logic [8:0] transmit_shift_register;
  logic [3:0] tx_left;
  logic tx_load;
  logic tx_end;
  logic wr_txbuf;
  logic [8:0] receive_shift_register;
  logic [3:0] rx_count;
  logic [3:0] rx_last;
  logic [8:0] next_rx_shift;
  logic rx_done;
  logic rx_push;
  logic rd_rxbuf;
  logic [8:0] rx_head;
  logic rx_empty;
  logic rx_full;
  logic transmit_buffer_empty_flag;
  logic receive_complete_flag;
  logic overrun_error_flag;
  logic pending;

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    hit = (adr[7:2] == ofs[7:2]);
  endfunction

  // Pins are asynchronous to clk_i
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_sync <= 3'h0;
      dat_sync <= 2'h0;
    end else begin
      clk_sync <= {clk_sync[1:0], link_clock_pin_i};
      dat_sync <= {dat_sync[0], link_data_pin_i};
    end
  end
  // Idle-low link clock: rising is leading, falling trailing
  assign lead_edge = clk_sync[1] && !clk_sync[2];
  assign trail_edge = !clk_sync[1] && clk_sync[2];

  assign slave_mode = rx_ctrl[`PORT_EN_BIT] && tx_ctrl[`SYNC_MODE_BIT] && !tx_ctrl[`CLK_SRC_BIT];
  assign rx_mode = slave_mode && rx_ctrl[`CONT_RX_BIT];
  assign tx_mode = slave_mode && tx_ctrl[`TX_EN_BIT]
    && !rx_ctrl[`CONT_RX_BIT] && !rx_ctrl[`SINGLE_RX_BIT];

  assign link_clock_pin_o = 1'b0;
  assign link_clock_pin_oe_o = 1'b0;
  assign link_data_pin_oe_o = tx_mode;

  // Wishbone slave, one wait state
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr = wb_req && wb_we_i && wb_sel_i[0];
  assign wr_txbuf = wb_wr && hit(wb_adr_i, `TX_DATA_BUF_OFS);
  assign rd_rxbuf = wb_req && !wb_we_i && hit(wb_adr_i, `RX_DATA_BUF_OFS);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        wb_dat_o <= next_rd_data;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_interrupt_control <= `CORE_INT_CTRL_RST;
      peripheral_interrupt_enables <= `PERIPH_INT_EN_RST;
      port_c_direction <= `PORT_C_DIR_RST;
      rx_ctrl <= 5'(`RX_STAT_CTRL_RST >> 3);
      tx_ctrl <= `TX_STAT_CTRL_RST;
    end else if (wb_wr) begin
      if (hit(wb_adr_i, `CORE_INT_CTRL_OFS)) begin
        core_interrupt_control <= wb_dat_i[7:0];
      end else if (hit(wb_adr_i, `PERIPH_INT_EN_OFS)) begin
        peripheral_interrupt_enables <= wb_dat_i[7:0];
      end else if (hit(wb_adr_i, `PORT_C_DIR_OFS)) begin
        port_c_direction <= wb_dat_i[7:0];
      end else if (hit(wb_adr_i, `RX_STAT_CTRL_OFS)) begin
        rx_ctrl <= wb_dat_i[7:3];
      end else if (hit(wb_adr_i, `TX_STAT_CTRL_OFS)) begin
        tx_ctrl <= wb_dat_i[7:0];
      end
    end
  end

  always_comb begin
    next_rd_data = 32'h0;
    if (hit(wb_adr_i, `CORE_INT_CTRL_OFS)) begin
      next_rd_data[7:0] = core_interrupt_control;
    end else if (hit(wb_adr_i, `PERIPH_INT_EN_OFS)) begin
      next_rd_data[7:0] = peripheral_interrupt_enables;
    end else if (hit(wb_adr_i, `PERIPH_INT_FLAG_OFS)) begin
      next_rd_data[`RX_FLAG_BIT] = receive_complete_flag;
      next_rd_data[`TX_FLAG_BIT] = transmit_buffer_empty_flag;
    end else if (hit(wb_adr_i, `RX_STAT_CTRL_OFS)) begin
      next_rd_data[7:3] = rx_ctrl;
      next_rd_data[`OVERRUN_BIT] = overrun_error_flag;
      next_rd_data[`RX_NINTH_BIT] = rx_head[8];
    end else if (hit(wb_adr_i, `PORT_C_DIR_OFS)) begin
      next_rd_data[7:0] = port_c_direction;
    end else if (hit(wb_adr_i, `TX_STAT_CTRL_OFS)) begin
      next_rd_data[7:0] = tx_ctrl;
      next_rd_data[3] = 1'b0;
      next_rd_data[`TX_SHIFT_EMPTY_BIT] = (tx_state == sync_slave_serial_port_pkg::TX_IDLE);
    end else if (hit(wb_adr_i, `RX_DATA_BUF_OFS)) begin
      next_rd_data[7:0] = rx_head[7:0];
    end
  end

  // Transmit holding buffer; a write in the load cycle still lands
  assign tx_load = tx_mode && txbuf_full && (tx_state == sync_slave_serial_port_pkg::TX_IDLE);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      transmit_data_buffer <= 9'h0;
      txbuf_full <= 1'b0;
    end else if (wr_txbuf) begin
      transmit_data_buffer <= {tx_ctrl[`TX_NINTH_BIT], wb_dat_i[7:0]};
      txbuf_full <= 1'b1;
    end else if (tx_load) begin
      txbuf_full <= 1'b0;
    end
  end
  assign transmit_buffer_empty_flag = !txbuf_full;

  assign tx_end = (tx_state == sync_slave_serial_port_pkg::TX_SHIFT) && trail_edge && (tx_left == 4'h1);
  // Leaving transmit mode drops a partial character
  always_ff @(posedge clk_i) begin
    if (rst_i || !tx_mode) begin
      tx_state <= sync_slave_serial_port_pkg::TX_IDLE;
      transmit_shift_register <= 9'h0;
      tx_left <= 4'h0;
      link_data_pin_o <= 1'b0;
    end else begin
      case (tx_state)
        sync_slave_serial_port_pkg::TX_IDLE: begin
          if (tx_load) begin
            transmit_shift_register <= transmit_data_buffer;
            tx_left <= tx_ctrl[`TX_NINE_EN_BIT] ? `CHAR_BITS_LONG : `CHAR_BITS_SHORT;
            link_data_pin_o <= transmit_data_buffer[0];
            tx_state <= sync_slave_serial_port_pkg::TX_SHIFT;
          end
        end
        default: begin
          if (lead_edge) begin
            link_data_pin_o <= transmit_shift_register[0];
          end
          if (trail_edge) begin
            transmit_shift_register <= transmit_shift_register >> 1;
            tx_left <= tx_left - 4'h1;
            if (tx_left == 4'h1) begin
              tx_state <= sync_slave_serial_port_pkg::TX_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Receiver; the single-receive bit has no effect here
  assign rx_last = rx_ctrl[`RX_NINE_EN_BIT] ? `CHAR_BITS_LONG : `CHAR_BITS_SHORT;
  assign next_rx_shift = {dat_sync[1], receive_shift_register[8:1]};
  assign rx_done = (rx_state == sync_slave_serial_port_pkg::RX_SHIFT) && trail_edge
    && (rx_count + 4'h1 == rx_last);
  // A read in the completing cycle frees a slot, so that is no overrun
  assign rx_push = rx_done && (!rx_full || rd_rxbuf);
  always_ff @(posedge clk_i) begin
    if (rst_i || !rx_mode) begin
      rx_state <= sync_slave_serial_port_pkg::RX_OFF;
      receive_shift_register <= 9'h0;
      rx_count <= 4'h0;
    end else begin
      case (rx_state)
        sync_slave_serial_port_pkg::RX_OFF: begin
          rx_state <= sync_slave_serial_port_pkg::RX_SHIFT;
        end
        sync_slave_serial_port_pkg::RX_SHIFT: begin
          if (trail_edge) begin
            receive_shift_register <= next_rx_shift;
            rx_count <= rx_done ? 4'h0 : rx_count + 4'h1;
            if (rx_done && rx_full && !rd_rxbuf) begin
              rx_state <= sync_slave_serial_port_pkg::RX_OVERRUN;
            end
          end
        end
        default: begin
          rx_state <= sync_slave_serial_port_pkg::RX_OVERRUN;
        end
      endcase
    end
  end
  assign overrun_error_flag = (rx_state == sync_slave_serial_port_pkg::RX_OVERRUN);

  char_fifo #(
    .WIDTH(9),
    .DEPTH(`RX_FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .push_i(rx_push),
    .data_i(rx_ctrl[`RX_NINE_EN_BIT] ? next_rx_shift : {1'b0, next_rx_shift[8:1]}),
    .pop_i(rd_rxbuf),
    .head_o(rx_head),
    .empty_o(rx_empty),
    .full_o(rx_full)
  );
  assign receive_complete_flag = !rx_empty;

  assign pending = core_interrupt_control[`PERIPH_INT_EN_BIT]
    && ((peripheral_interrupt_enables[`TX_INT_EN_BIT] && transmit_buffer_empty_flag)
    || (peripheral_interrupt_enables[`RX_INT_EN_BIT] && receive_complete_flag));
  assign wake_o = sleep_i && pending;
  assign interrupt_o = pending && core_interrupt_control[`GLOBAL_INT_EN_BIT];

  sequence s_last_bit_with_wait;
    tx_end && txbuf_full && !wr_txbuf ##1 !wr_txbuf && tx_mode;
  endsequence
  sequence s_third_char;
    rx_done && rx_full && !rd_rxbuf && rx_mode;
  endsequence

  AST_TX_LOAD_AT_ONCE: assert property (@(posedge clk_i) disable iff (rst_i)
    tx_load && !wr_txbuf |=> tx_state == sync_slave_serial_port_pkg::TX_SHIFT
      && transmit_shift_register == $past(transmit_data_buffer) && transmit_buffer_empty_flag)
    else $error("Buffered character not moved to shift register");
  AST_TX_SECOND_WAITS: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_txbuf && tx_state == sync_slave_serial_port_pkg::TX_SHIFT && !tx_end && tx_mode
      |=> !transmit_buffer_empty_flag && tx_state == sync_slave_serial_port_pkg::TX_SHIFT)
    else $error("Second character did not wait");
  AST_TX_REFILL: assert property (@(posedge clk_i) disable iff (rst_i)
    s_last_bit_with_wait |=> tx_state == sync_slave_serial_port_pkg::TX_SHIFT && transmit_buffer_empty_flag)
    else $error("Waiting character not loaded after shift-out");
  AST_TX_NINE_BITS: assert property (@(posedge clk_i) disable iff (rst_i)
    tx_load |=> tx_left == ($past(tx_ctrl[`TX_NINE_EN_BIT]) ? 4'h9 : 4'h8))
    else $error("Wrong character length loaded");
  AST_TRANSMIT_ENABLE_GATES: assert property (@(posedge clk_i) disable iff (rst_i)
    !tx_mode |-> !link_data_pin_oe_o
      ##1 (tx_state == sync_slave_serial_port_pkg::TX_IDLE && !link_data_pin_o))
    else $error("Transmitter active without enable");
  AST_TX_LEAD_EDGE: assert property (@(posedge clk_i) disable iff (rst_i)
    tx_mode && tx_state == sync_slave_serial_port_pkg::TX_SHIFT && !trail_edge
      |=> link_data_pin_o == $past(link_data_pin_o) || $past(lead_edge))
    else $error("Data changed away from leading edge");
  AST_RX_ONLY_CONT: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_state != sync_slave_serial_port_pkg::RX_OFF |-> $past(rx_ctrl[`CONT_RX_BIT]))
    else $error("Receiver running without continuous receive");
  AST_RX_FLAG_SETS: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_push |=> receive_complete_flag ##1 (receive_complete_flag || $past(rd_rxbuf)))
    else $error("Receive flag not set after character");
  AST_OVERRUN_KEEPS: assert property (@(posedge clk_i) disable iff (rst_i)
    s_third_char |=> overrun_error_flag && $stable(rx_head) && rx_full)
    else $error("Overrun did not hold stored data");
  AST_OVERRUN_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
    overrun_error_flag && !rx_ctrl[`CONT_RX_BIT] |=> !overrun_error_flag)
    else $error("Overrun not cleared by continuous receive off");
  AST_CLK_DRIVER_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
    slave_mode |-> !link_clock_pin_oe_o)
    else $error("Clock pin driven in slave mode");
  AST_RX_NINE_HEAD: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_push && rx_empty && rx_ctrl[`RX_NINE_EN_BIT] |=> rx_head == $past(next_rx_shift))
    else $error("Ninth received bit not presented");
  AST_IDLE_OUT_OF_SLAVE: assert property (@(posedge clk_i) disable iff (rst_i)
    !slave_mode |=> tx_state == sync_slave_serial_port_pkg::TX_IDLE
      && rx_state == sync_slave_serial_port_pkg::RX_OFF)
    else $error("Shift logic running outside slave mode");
  AST_WAKE_RX: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_push && sleep_i && peripheral_interrupt_enables[`RX_INT_EN_BIT]
      && core_interrupt_control[`PERIPH_INT_EN_BIT] |=> ##0 (!sleep_i || wake_o))
    else $error("Received character failed to wake core");
endmodule
`default_nettype wire

// File: src/sync_slave_serial_port_consts.svh
// Register offsets, field positions and reset values of the serial port
`ifndef SYNC_SLAVE_SERIAL_PORT_CONSTS_SVH
`define SYNC_SLAVE_SERIAL_PORT_CONSTS_SVH

`define CORE_INT_CTRL_OFS 8'h00
`define PERIPH_INT_EN_OFS 8'h04
`define PERIPH_INT_FLAG_OFS 8'h08
`define RX_STAT_CTRL_OFS 8'h0c
`define PORT_C_DIR_OFS 8'h10
`define TX_DATA_BUF_OFS 8'h14
`define TX_STAT_CTRL_OFS 8'h18
`define RX_DATA_BUF_OFS 8'h1c

`define GLOBAL_INT_EN_BIT 7
`define PERIPH_INT_EN_BIT 6
`define RX_INT_EN_BIT 5
`define TX_INT_EN_BIT 4
`define RX_FLAG_BIT 5
`define TX_FLAG_BIT 4

`define PORT_EN_BIT 7
`define RX_NINE_EN_BIT 6
`define SINGLE_RX_BIT 5
`define CONT_RX_BIT 4
`define ADDR_DET_BIT 3
`define OVERRUN_BIT 1
`define RX_NINTH_BIT 0

`define CLK_SRC_BIT 7
`define TX_NINE_EN_BIT 6
`define TX_EN_BIT 5
`define SYNC_MODE_BIT 4
`define BAUD_HIGH_BIT 2
`define TX_SHIFT_EMPTY_BIT 1
`define TX_NINTH_BIT 0

`define CORE_INT_CTRL_RST 8'h00
`define PERIPH_INT_EN_RST 8'h00
`define PORT_C_DIR_RST 8'hff
`define RX_STAT_CTRL_RST 8'h00
`define TX_STAT_CTRL_RST 8'h02

`define CHAR_BITS_SHORT 4'h8
`define CHAR_BITS_LONG 4'h9
`define RX_FIFO_DEPTH 2

`endif

// File: src/sync_slave_serial_port_pkg.sv
// Types shared by the serial port design
`default_nettype none
package sync_slave_serial_port_pkg;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SHIFT = 2'b01
  } tx_state_t;
  typedef enum logic [1:0] {
    RX_OFF = 2'b00,
    RX_SHIFT = 2'b01,
    RX_OVERRUN = 2'b11
  } rx_state_t;
endpackage
`default_nettype wire

// File: verif/sync_master_model.sv
// Behavioural external master that clocks the link and trades bits with the port
`default_nettype none
module sync_master_model (
  output logic link_clk_o, // Link clock to the port
  output logic dat_o, // Master data drive
  input wire logic dat_i // Resolved data line
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    link_clk_o = 1'b0;
    dat_o = 1'b1;
  end
  // Clock stands low between frames; 200 ns period, one clock per bit, LSB first
  task automatic xfer(input int nbits, input logic [8:0] tx, output logic [8:0] rx);
    rx = 9'h000;
    // Keep pin changes off the system clock edges
    #5;
    for (int i = 0; i < nbits; i++) begin
      #50 dat_o = tx[i];
      #50 link_clk_o = 1'b1;
      #100 link_clk_o = 1'b0;
      rx[i] = dat_i;
    end
    // Released line must not keep showing the last bit
    #50 dat_o = ~dat_o;
  endtask
endmodule
`default_nettype wire

// File: verif/sync_slave_serial_port_tb.sv
// Self-checking bench for the synchronous slave serial port
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module sync_slave_serial_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic sleep_i = 1'b0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, link_clock_pin_i, link_clock_pin_o, link_clock_pin_oe_o;
  logic link_data_pin_o, link_data_pin_oe_o, wake_o, interrupt_o, m_dat;
  wire link_data_pin_i;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc_cnt = 0;
  logic [7:0] q;
  logic [8:0] rx;
  assign link_data_pin_i = link_data_pin_oe_o ? link_data_pin_o : m_dat;
  sync_slave_serial_port sync_slave_serial_port_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .link_clock_pin_i, .link_clock_pin_o, .link_clock_pin_oe_o,
    .link_data_pin_i, .link_data_pin_o, .link_data_pin_oe_o, .sleep_i, .wake_o, .interrupt_o);
  sync_master_model sync_master_model_i (.link_clk_o(link_clock_pin_i), .dat_o(m_dat), .dat_i(link_data_pin_i));
  always #12.5 clk_i = ~clk_i;
  task automatic wrap_up;
    $display("Checks %0d, errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Hang guard, far above the several hundred cycles the run needs
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end
  task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= {24'h000000, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic chk_rd(input string nm, input logic [7:0] adr, input logic [7:0] e);
    wb(1'b0, adr, 8'h00);
    `CHK(nm, e, q)
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic t_reset;
    logic [7:0] ofs [9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20};
    logic [7:0] rv [9] = '{8'h00, 8'h00, 8'h10, 8'h00, 8'hff, 8'h00, 8'h02, 8'h00, 8'h00};
    for (int i = 0; i < 9; i++)
      chk_rd("reset_value", ofs[i], rv[i]);
    wb(1'b1, 8'h10, 8'h5a);
    chk_rd("direction_rw", 8'h10, 8'h5a);
    wb(1'b1, 8'h08, 8'hff);
    chk_rd("flags_ro", 8'h08, 8'h10);
    `CHK("clock_pin_oe", 1'b0, link_clock_pin_oe_o)
    `CHK("clock_pin_val", 1'b0, link_clock_pin_o)
  endtask
  task automatic t_tx;
    wb(1'b1, 8'h0c, 8'h80);
    wb(1'b1, 8'h18, 8'h30);
    wb(1'b1, 8'h04, 8'h10);
    wb(1'b1, 8'h00, 8'h40);
    wb(1'b1, 8'h14, 8'ha5);
    wb(1'b1, 8'h14, 8'h3c);
    tick(4);
    chk_rd("tx_flag_waiting", 8'h08, 8'h00);
    sleep_i <= 1'b1;
    tick(2);
    `CHK("wake_idle", 1'b0, wake_o)
    `CHK("clock_pin_oe_slave", 1'b0, link_clock_pin_oe_o)
    sync_master_model_i.xfer(8, 9'h000, rx);
    `CHK("tx_first", 9'h0a5, rx)
    tick(10);
    `CHK("wake_on_tx", 1'b1, wake_o)
    `CHK("no_vector", 1'b0, interrupt_o)
    wb(1'b1, 8'h00, 8'hc0);
    tick(1);
    `CHK("vector_on_tx", 1'b1, interrupt_o)
    sync_master_model_i.xfer(8, 9'h000, rx);
    `CHK("tx_second", 9'h03c, rx)
    @(posedge clk_i);
    sleep_i <= 1'b0;
    wb(1'b1, 8'h00, 8'h00);
  endtask
  task automatic t_tx9;
    wb(1'b1, 8'h18, 8'h71);
    wb(1'b1, 8'h14, 8'h5a);
    tick(4);
    `CHK("tx_pin_driven", 1'b1, link_data_pin_oe_o)
    sync_master_model_i.xfer(9, 9'h000, rx);
    `CHK("tx_nine", 9'h15a, rx)
    wb(1'b1, 8'h18, 8'h10);
    tick(1);
    `CHK("tx_pin_off", 1'b0, link_data_pin_oe_o)
  endtask
  task automatic t_rx;
    chk_rd("rx_empty", 8'h08, 8'h10);
    wb(1'b1, 8'h04, 8'h20);
    wb(1'b1, 8'h00, 8'h40);
    wb(1'b1, 8'h0c, 8'hb0);
    sleep_i <= 1'b1;
    sync_master_model_i.xfer(8, 9'h0c3, rx);
    tick(10);
    `CHK("wake_on_rx", 1'b1, wake_o)
    chk_rd("rx_flag", 8'h08, 8'h30);
    sync_master_model_i.xfer(8, 9'h07e, rx);
    sync_master_model_i.xfer(8, 9'h0ff, rx);
    repeat (10) @(posedge clk_i);
    sleep_i <= 1'b0;
    chk_rd("overrun_set", 8'h0c, 8'hb2);
    chk_rd("rx_first", 8'h1c, 8'hc3);
    chk_rd("rx_second", 8'h1c, 8'h7e);
    chk_rd("rx_drained", 8'h08, 8'h10);
    wb(1'b1, 8'h0c, 8'h80);
    chk_rd("overrun_cleared", 8'h0c, 8'h80);
  endtask
  task automatic t_rx9;
    wb(1'b1, 8'h0c, 8'hd0);
    sync_master_model_i.xfer(9, 9'h1a5, rx);
    tick(10);
    chk_rd("rx_ninth", 8'h0c, 8'hd1);
    chk_rd("rx_low", 8'h1c, 8'ha5);
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_tx();
    t_tx9();
    t_rx();
    t_rx9();
    wrap_up();
  end
endmodule
`default_nettype wire
